// [nasd_datapath.sv]
// execution datapath for the nibble alu, table lookup and skip tests
// assumes the sequencer issues one instruction per issue pulse, supplies the
// memory nibble at the data pointer combinationally, and returns rom data the
// cycle after rom_req with rom_valid
// assumes every input comes from same-clock logic, so none is synchronised
// Functional notes
// - immediate load writes the 4-bit operand into the accumulator
// - in a run of back-to-back immediate loads only the first executes
// - table lookup puts rom bits 7..4 in high nibble, 3..0 in accumulator
// - lookup address is pointer bits high, accumulator low, within given page
// - upper-table flag set: rom bits 9,8 to pointer bits 1,0, bit 2 cleared
// - table lookup occupies one return stack level while it runs
// - plain add stores memory plus accumulator, carry flag unchanged
// - add with carry stores sum in accumulator and carry out in carry flag
// - add immediate keeps carry, skips next unless overflow occurs
// - logical and of accumulator with memory nibble
// - logical or of accumulator with memory nibble
// - carry set forces one, carry clear forces zero
// - carry test skips next instruction when carry flag is zero
// - complement replaces accumulator with its one's complement
// - rotate carry and accumulator right by one through carry
// - bit set or clear writes indexed memory bit, others kept
// - bit test skips next when indexed memory bit is zero
// - compare with memory skips next when equal
// - compare immediate skips next when equal
`timescale 1ns/10ps
`default_nettype none
module nasd_datapath (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic                               issue,
  input  wire nasd_pkg::nasd_instr_t              instr,
  input  wire logic [nasd_pkg::NIB_W-1:0]         memory_at_data_pointer,
  input  wire logic                               upper_table_bits_flag,
  input  wire logic [nasd_pkg::ROM_W-1:0]         rom_data,
  input  wire logic                               rom_valid,
  output logic                                    rom_req,
  output logic [nasd_pkg::PAGE_W-1:0]             rom_page,
  output logic [nasd_pkg::TBL_ADR_W-1:0]          rom_addr,
  output logic                                    return_stack_hold,
  output nasd_pkg::nasd_mem_wr_t                  mem_wr,
  output logic                                    busy,
  output logic                                    skip_next,
  output logic [nasd_pkg::NIB_W-1:0]              acc,
  output logic [nasd_pkg::NIB_W-1:0]              hi_nibble,
  output logic                                    carry_flag,
  output logic                                    pointer_bit_two,
  output logic                                    pointer_bit_one,
  output logic                                    pointer_bit_zero
);
  import nasd_pkg::*;

  // lookup sequencing: idle, or waiting for the rom word
  typedef enum logic [0:0] {
    NASD_IDLE = 1'b0,
    NASD_WAIT = 1'b1
  } nasd_state_t;

  nasd_state_t       state;
  logic              skip_pending;
  logic              prev_was_ldi;
  logic              taken;
  logic              exec;
  logic              is_ldi;
  logic              rom_take;
  logic [NIB_W:0]    sum_mem;
  logic [NIB_W:0]    sum_adc;
  logic [NIB_W:0]    sum_imm;
  logic [1:0]        bit_idx;
  logic              next_skip;
  logic [NIB_W-1:0]  next_mem_data;

  // a slot offered during a lookup is refused, so a stray issue cannot
  // disturb the skip or load-run history
  assign taken = issue && (state == NASD_IDLE);

  // an instruction in a skipped slot only consumes its slot
  assign is_ldi = (instr.op == NASD_LDI);
  assign exec   = taken && !skip_pending && !(is_ldi && prev_was_ldi);

  // two-bit index of the bit instructions
  assign bit_idx = instr.imm[1:0];

  // a rom word only counts while a lookup waits; a stray pulse is dropped
  assign rom_take = (state == NASD_WAIT) && rom_valid;

  // 5-bit sums so the carry out of bit 3 is visible
  assign sum_mem = {1'b0, acc} + {1'b0, memory_at_data_pointer};
  // carry in joins at bit 0, carry out lands in bit 4
  assign sum_adc = sum_mem + {{NIB_W{1'b0}}, carry_flag};
  assign sum_imm = {1'b0, acc} + {1'b0, instr.imm};

  // skip decisions for the following instruction
  always_comb begin
    next_skip = 1'b0;
    if (exec) begin
      case (instr.op)
        NASD_ADI: begin
          next_skip = !sum_imm[NIB_W];
        end
        NASD_TSTC: begin
          next_skip = !carry_flag;
        end
        NASD_BTST: begin
          next_skip = !memory_at_data_pointer[bit_idx];
        end
        NASD_CMPM: begin
          next_skip = (acc == memory_at_data_pointer);
        end
        NASD_CMPI: begin
          next_skip = (acc == instr.imm);
        end
        default: begin
          next_skip = 1'b0;
        end
      endcase
    end
  end

  // combinational so the sequencer sees the decision in the issue slot
  assign skip_next = next_skip;

  // skip flag lives until the next taken slot is consumed
  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_pending <= 1'b0;
    end else if (taken) begin
      skip_pending <= next_skip;
    end
  end

  // the repeat-load chain tracks taken slots, skipped or not
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_was_ldi <= 1'b0;
    end else if (taken) begin
      prev_was_ldi <= is_ldi;
    end
  end

  // table lookup handshake: request pulse, page and address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state    <= NASD_IDLE;
      rom_req  <= 1'b0;
      rom_page <= '0;
      rom_addr <= '0;
    end else begin
      rom_req <= 1'b0;
      case (state)
        NASD_IDLE: begin
          if (exec && instr.op == NASD_TBL) begin
            state    <= NASD_WAIT;
            rom_req  <= 1'b1;
            rom_page <= instr.page;
            rom_addr <= {pointer_bit_two, pointer_bit_one,
                         pointer_bit_zero, acc};
          end
        end
        NASD_WAIT: begin
          if (rom_valid) begin
            state <= NASD_IDLE;
          end
        end
        default: begin
          state <= NASD_IDLE;
        end
      endcase
    end
  end

  // one stack level held from the cycle after issue until the word lands;
  // the stack itself lives outside, this only tells it a level is taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      return_stack_hold <= 1'b0;
    end else if (exec && instr.op == NASD_TBL) begin
      return_stack_hold <= 1'b1;
    end else if (rom_take) begin
      return_stack_hold <= 1'b0;
    end
  end

  // the sequencer must not issue while busy; lookup needs the rom turn-around
  assign busy = (state == NASD_WAIT);

  // accumulator; the rom word wins, as no slot is taken while it is awaited
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc <= ACC_RST;
    end else if (rom_take) begin
      acc <= rom_data[NIB_W-1:0];
    end else if (exec) begin
      case (instr.op)
        NASD_LDI: begin
          acc <= instr.imm;
        end
        NASD_ADD: begin
          acc <= sum_mem[NIB_W-1:0];
        end
        NASD_ADC: begin
          acc <= sum_adc[NIB_W-1:0];
        end
        NASD_ADI: begin
          acc <= sum_imm[NIB_W-1:0];
        end
        NASD_AND: begin
          acc <= acc & memory_at_data_pointer;
        end
        NASD_OR: begin
          acc <= acc | memory_at_data_pointer;
        end
        NASD_CPL: begin
          acc <= ~acc;
        end
        NASD_ROR: begin
          acc <= {carry_flag, acc[NIB_W-1:1]};
        end
        default: begin
          acc <= acc;
        end
      endcase
    end
  end

  // carry flag; plain add and add-immediate leave it alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carry_flag <= CY_RST;
    end else if (exec) begin
      case (instr.op)
        NASD_ADC: begin
          carry_flag <= sum_adc[NIB_W];
        end
        NASD_SETC: begin
          carry_flag <= 1'b1;
        end
        NASD_CLRC: begin
          carry_flag <= 1'b0;
        end
        NASD_ROR: begin
          carry_flag <= acc[0];
        end
        default: begin
          carry_flag <= carry_flag;
        end
      endcase
    end
  end

  // high nibble from the rom word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_nibble <= HI_RST;
    end else if (rom_take) begin
      hi_nibble <= rom_data[ROM_HI_MSB:ROM_HI_LSB];
    end
  end

  // pointer bits: only an upper-table lookup rewrites them here; other
  // pointer loads belong to instructions outside this block
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pointer_bit_two  <= PTR_RST[2];
      pointer_bit_one  <= PTR_RST[1];
      pointer_bit_zero <= PTR_RST[0];
    end else if (rom_take && upper_table_bits_flag) begin
      pointer_bit_two  <= 1'b0;
      pointer_bit_one  <= rom_data[ROM_UP_MSB];
      pointer_bit_zero <= rom_data[ROM_UP_LSB];
    end
  end

  // new nibble for a bit write: the addressed bit forced, the others kept
  always_comb begin
    next_mem_data = memory_at_data_pointer;
    case (instr.op)
      NASD_BSET: begin
        next_mem_data[bit_idx] = 1'b1;
      end
      NASD_BCLR: begin
        next_mem_data[bit_idx] = 1'b0;
      end
      default: begin
        next_mem_data = memory_at_data_pointer;
      end
    endcase
  end

  // memory bit writes; presented the cycle after issue, written by memory
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_wr <= '0;
    end else begin
      mem_wr.we   <= exec && (instr.op == NASD_BSET || instr.op == NASD_BCLR);
      mem_wr.data <= next_mem_data;
    end
  end
endmodule
`default_nettype wire

// [nasd_pkg.sv]
// package for the nibble alu / skip datapath
// assumes a decoder that hands over one decoded operation per issue strobe
package nasd_pkg;
  localparam int NIB_W     = 4;
  localparam int ROM_W     = 10;
  localparam int PAGE_W    = 5;
  localparam int TBL_ADR_W = 7;
  localparam int ROM_HI_MSB = 7;
  localparam int ROM_HI_LSB = 4;
  localparam int ROM_UP_MSB = 9;
  localparam int ROM_UP_LSB = 8;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] HI_RST  = 4'h0;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic       CY_RST  = 1'b0;

  // decoded operation codes for this datapath
  typedef enum logic [4:0] {
    NASD_NOP   = 5'b0_0000,
    NASD_LDI   = 5'b0_0001,
    NASD_TBL   = 5'b0_0010,
    NASD_ADD   = 5'b0_0011,
    NASD_ADC   = 5'b0_0100,
    NASD_ADI   = 5'b0_0101,
    NASD_AND   = 5'b0_0110,
    NASD_OR    = 5'b0_0111,
    NASD_SETC  = 5'b0_1000,
    NASD_CLRC  = 5'b0_1001,
    NASD_TSTC  = 5'b0_1010,
    NASD_CPL   = 5'b0_1011,
    NASD_ROR   = 5'b0_1100,
    NASD_BSET  = 5'b0_1101,
    NASD_BCLR  = 5'b0_1110,
    NASD_BTST  = 5'b0_1111,
    NASD_CMPM  = 5'b1_0000,
    NASD_CMPI  = 5'b1_0001
  } nasd_op_t;

  // one issued instruction from the decoder
  typedef struct packed {
    nasd_op_t                  op;
    logic [NIB_W-1:0]          imm;
    logic [PAGE_W-1:0]         page;
  } nasd_instr_t;

  // data memory write request
  typedef struct packed {
    logic             we;
    logic [NIB_W-1:0] data;
  } nasd_mem_wr_t;
endpackage

// [nasd_datapath_chk.sv]
// port checker for the nibble alu / skip datapath
// assumes a single core clock and binding onto nasd_datapath
`timescale 1ns/10ps
`default_nettype none
module nasd_datapath_chk
  import nasd_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  issue,
  input wire nasd_pkg::nasd_instr_t instr,
  input wire logic [3:0]            memory_at_data_pointer,
  input wire logic                  upper_table_bits_flag,
  input wire logic [9:0]            rom_data,
  input wire logic                  rom_valid,
  input wire logic                  rom_req,
  input wire logic [6:0]            rom_addr,
  input wire logic                  return_stack_hold,
  input wire nasd_pkg::nasd_mem_wr_t mem_wr,
  input wire logic                  busy,
  input wire logic                  skip_next,
  input wire logic [3:0]            acc,
  input wire logic [3:0]            hi_nibble,
  input wire logic                  carry_flag,
  input wire logic                  pointer_bit_two,
  input wire logic                  pointer_bit_one,
  input wire logic                  pointer_bit_zero
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sk;
  logic ld;
  wire  tk = issue && !busy;
  wire  ex = tk && !sk;
  // skip and load-run state of the last taken slot; skipped loads still count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sk <= 1'b0;
      ld <= 1'b0;
    end else if (tk) begin
      sk <= skip_next;
      ld <= instr.op == NASD_LDI;
    end
  end
  a_load_first: assert property (ex && instr.op == NASD_LDI && !ld
    |=> acc == $past(instr.imm)) else $error("load missed");
  a_load_repeat: assert property (tk && instr.op == NASD_LDI && ld
    |=> $stable(acc)) else $error("repeat load acted");
  a_skip_quiet: assert property (tk && sk
    |=> $stable(acc) && $stable(carry_flag) && !mem_wr.we && !rom_req) else $error("skip acted");
  a_add_carry: assert property (ex && instr.op == NASD_ADC |=> {carry_flag, acc} ==
    {1'b0, $past(acc)} + $past(memory_at_data_pointer) + $past(carry_flag))
    else $error("adc wrong");
  a_imm_skip: assert property (ex && instr.op == NASD_ADI
    |-> skip_next == (5'(acc) + 5'(instr.imm) < 5'h10)) else $error("adi skip wrong");
  a_cmp_imm: assert property (ex && instr.op == NASD_CMPI
    |-> skip_next == (acc == instr.imm)) else $error("cmpi skip wrong");
  a_rom_start: assert property (ex && instr.op == NASD_TBL
    |=> rom_req && busy && return_stack_hold && rom_addr == {$past(pointer_bit_two),
    $past(pointer_bit_one), $past(pointer_bit_zero), $past(acc)}) else $error("lookup start");
  a_lookup_load: assert property (busy && rom_valid
    |=> {hi_nibble, acc} == $past(rom_data[7:0])) else $error("lookup data");
  a_upper_ptr: assert property (busy && rom_valid && upper_table_bits_flag
    |=> {pointer_bit_two, pointer_bit_one, pointer_bit_zero} == {1'b0, $past(rom_data[9:8])})
    else $error("upper pointer bits");
  a_hold_drop: assert property (busy && rom_valid
    |=> !busy && !return_stack_hold) else $error("stack level kept");
endmodule
bind nasd_datapath nasd_datapath_chk i_chk (.*);
`default_nettype wire

// [tb.sv]
// self-checking bench for nasd_datapath
// assumes the checker file binds itself; inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
module tb;
  import nasd_pkg::*;
  logic         core_clk, rst, issue, upper_table_bits_flag, rom_valid, sk;
  nasd_instr_t  instr;
  logic [3:0]   memory_at_data_pointer, acc, hi_nibble;
  logic [9:0]   rom_data;
  logic [4:0]   rom_page;
  logic [6:0]   rom_addr;
  nasd_mem_wr_t mem_wr;
  logic         rom_req, return_stack_hold, busy, skip_next, carry_flag;
  logic         pointer_bit_two, pointer_bit_one, pointer_bit_zero;
  int           fails, comparisons;
  nasd_datapath i_dut (.*);
  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // offers one slot; skip flag read before the edge since it is combinational
  task automatic iss(input nasd_op_t o, input logic [3:0] i, input logic [3:0] m);
    issue = 1'b1;
    instr = {o, i, 5'h05};
    memory_at_data_pointer = m;
    #1 sk = skip_next;
    @(negedge core_clk);
  endtask
  task automatic t_arith;
    iss(NASD_SETC, 4'h0, 4'h0);
    iss(NASD_ADD, 4'h0, 4'h7);
    chk({carry_flag, acc}, 5'h1C);
    iss(NASD_ADC, 4'h0, 4'h6);
    chk({carry_flag, acc}, 5'h13);
    iss(NASD_ADI, 4'hF, 4'h0);
    chk({sk, carry_flag, acc}, 6'h12);
    iss(NASD_ADI, 4'h1, 4'h0);
    chk({sk, carry_flag, acc}, 6'h33);
    iss(NASD_CPL, 4'h0, 4'h0);
    chk(acc, 4'h3);
    iss(NASD_CPL, 4'h0, 4'h0);
    chk(acc, 4'hC);
    iss(NASD_CLRC, 4'h0, 4'h0);
    chk(carry_flag, 1'b0);
    iss(NASD_TSTC, 4'h0, 4'h0);
    chk(sk, 1'b1);
    iss(NASD_SETC, 4'h0, 4'h0);
    chk(carry_flag, 1'b0);
    iss(NASD_SETC, 4'h0, 4'h0);
    iss(NASD_TSTC, 4'h0, 4'h0);
    chk(sk, 1'b0);
    iss(NASD_ROR, 4'h0, 4'h0);
    chk({carry_flag, acc}, 5'h0E);
    iss(NASD_AND, 4'h0, 4'h3);
    chk(acc, 4'h2);
    iss(NASD_OR, 4'h0, 4'h8);
    chk(acc, 4'hA);
    iss(NASD_CMPM, 4'h0, 4'h5);
    chk(sk, 1'b0);
    iss(NASD_CMPM, 4'h0, 4'hA);
    chk(sk, 1'b1);
    iss(NASD_TBL, 4'h0, 4'h0);
    chk({rom_req, busy, return_stack_hold}, 3'b000);
    iss(NASD_CMPI, 4'hB, 4'h0);
    chk(sk, 1'b0);
    iss(NASD_CMPI, 4'hA, 4'h0);
    chk(sk, 1'b1);
    iss(NASD_NOP, 4'h0, 4'h0);
    $display("arith test done");
  endtask
  task automatic t_bits;
    for (int j = 0; j < 4; j++) begin
      iss(NASD_BSET, 4'(j), 4'h6);
      chk({mem_wr.we, mem_wr.data}, {1'b1, 4'h6 | (4'h1 << j)});
      iss(NASD_BCLR, 4'(j), 4'h9);
      chk({mem_wr.we, mem_wr.data}, {1'b1, 4'h9 & ~(4'h1 << j)});
      iss(NASD_BTST, 4'(j), 4'h1 << j);
      chk(sk, 1'b0);
      chk(mem_wr.we, 1'b0);
      iss(NASD_BTST, 4'(j), ~(4'h1 << j));
      chk(sk, 1'b1);
      iss(NASD_NOP, 4'h0, 4'h0);
    end
    $display("bit test done");
  endtask
  // one lookup; released rom lines show the inverse so stale data cannot pass
  task automatic look(input logic [9:0] d, input logic f, input logic [6:0] a,
                      input logic [2:0] p);
    iss(NASD_TBL, 4'h0, 4'h0);
    issue = 1'b0;
    chk({rom_req, busy, return_stack_hold, rom_page, rom_addr}, {3'b111, 5'h05, a});
    rom_valid = 1'b1;
    rom_data = d;
    upper_table_bits_flag = f;
    @(negedge core_clk);
    rom_valid = 1'b0;
    rom_data = ~d;
    chk({hi_nibble, acc}, d[7:0]);
    chk({pointer_bit_two, pointer_bit_one, pointer_bit_zero, busy}, {p, 1'b0});
    chk({rom_req, return_stack_hold}, 2'b00);
    $display("lookup test done");
  endtask
  initial begin
    repeat (600) @(posedge core_clk);
    fails++;
    close_out;
  end
  initial begin
    {rst, issue, upper_table_bits_flag, rom_valid, sk} = 5'h1_0;
    instr = '0;
    memory_at_data_pointer = 4'h0;
    rom_data = 10'h000;
    fails = 0;
    comparisons = 0;
    repeat (12) @(negedge core_clk);
    chk({acc, hi_nibble, carry_flag, pointer_bit_two, pointer_bit_one, pointer_bit_zero}, 12'h000);
    rst = 1'b0;
    iss(NASD_LDI, 4'h5, 4'h0);
    chk(acc, 4'h5);
    iss(NASD_LDI, 4'h9, 4'h0);
    chk(acc, 4'h5);
    iss(NASD_LDI, 4'h3, 4'h0);
    chk(acc, 4'h5);
    $display("load test done");
    t_arith;
    t_bits;
    look(10'h2A5, 1'b1, 7'h0A, 3'b010);
    look(10'h13C, 1'b0, 7'h25, 3'b010);
    close_out;
  end
endmodule
`default_nettype wire
